//--- rtl/prs_pkg.sv
// Constants for the second peripheral soft-reset register.
// Assumes a plain address/strobe register port on the system clock.
// Operation
// - A write changes only the bits that the fourth capability mask marks present.
// - The register sits at offset 0x048 and clears to zero on reset.
// - Bit 30 is a read/write control that resets the Ethernet physical-layer unit.
// - Bit 28 is a read/write control that resets the Ethernet MAC unit.
// - Bits 0 to 6 are read/write controls resetting ports A to G in order.
// - Bits 31, 29 and 27 to 7 are reserved, read zero and ignore writes.
package prs_pkg;
	localparam int          PRS_ADDR_W       = 12;
	localparam logic [11:0] PRS_CTRL_TWO_OFS = 12'h048;
	localparam logic [31:0] PRS_CTRL_RESET   = 32'h00000000;
	localparam int          PRS_PHY_BIT      = 30;
	localparam int          PRS_MAC_BIT      = 28;
	localparam int          PRS_PORT_LO      = 0;
	localparam int          PRS_PORT_N       = 7;
	localparam logic [31:0] PRS_WR_MASK      = 32'h5000007f;
endpackage : prs_pkg

//--- rtl/prs_reset_two.sv
// Second peripheral soft-reset control register with capability gating.
// Assumes bus, capability mask and clock enable come from clk_sys logic.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module prs_reset_two
	import prs_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire logic [PRS_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [31:0]           reg_rdata,
	input  wire logic [31:0]           capability_mask_four,
	output logic                       phy_unit_reset,
	output logic                       mac_unit_reset,
	output logic      [PRS_PORT_N-1:0] port_reset
);

	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	logic        hit;

	assign hit = (reg_addr == PRS_CTRL_TWO_OFS);

	// Bits that a write may touch: writable and reported present
	function automatic logic [31:0] prs_wr_en(input logic [31:0] present);
		return PRS_WR_MASK & present;
	endfunction : prs_wr_en

	// Absent peripherals and reserved bits keep their stored value
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (reg_wr && hit) begin
			ctrl_nxt = (ctrl_r & ~prs_wr_en(capability_mask_four))
				| (reg_wdata & prs_wr_en(capability_mask_four));
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_r <= PRS_CTRL_RESET;
		end else if (clk_en) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Unmapped addresses read zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (clk_en) begin
			if (reg_rd && hit) begin
				reg_rdata <= ctrl_r;
			end else begin
				reg_rdata <= 32'h00000000;
			end
		end
	end

	// Reset outputs registered so they stay glitch free into peripherals.
	// They load from ctrl_nxt so a write reaches the pins on the same edge
	// as the register, with no extra cycle of latency.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			phy_unit_reset <= 1'b0;
		end else if (clk_en) begin
			phy_unit_reset <= ctrl_nxt[PRS_PHY_BIT];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mac_unit_reset <= 1'b0;
		end else if (clk_en) begin
			mac_unit_reset <= ctrl_nxt[PRS_MAC_BIT];
		end
	end

	// One flop per port, bit p holding port A plus p in reset
	for (genvar p = 0; p < PRS_PORT_N; p++) begin : g_port
		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				port_reset[p] <= 1'b0;
			end else if (clk_en) begin
				port_reset[p] <= ctrl_nxt[PRS_PORT_LO+p];
			end
		end

		a_port_sets: assert property (@(posedge clk_sys) disable iff (rst)
			(clk_en && reg_wr && hit && capability_mask_four[PRS_PORT_LO+p])
			|=> (port_reset[p] == $past(reg_wdata[PRS_PORT_LO+p])))
			else $error("Port reset bit not written");

		a_port_hold: assert property (@(posedge clk_sys) disable iff (rst)
			(!(clk_en && reg_wr && hit) && port_reset[p]) |=> port_reset[p])
			else $error("Port released without write");

		a_port_low: assert property (@(posedge clk_sys) disable iff (rst)
			(!(clk_en && reg_wr && hit) && !port_reset[p]) |=> !port_reset[p])
			else $error("Port reset rose without write");

		// An absent port must never be put into reset by software
		a_port_absent: assert property (@(posedge clk_sys) disable iff (rst)
			(clk_en && reg_wr && !capability_mask_four[PRS_PORT_LO+p])
			|=> $stable(port_reset[p]))
			else $error("Absent port reset changed");
	end

	a_gate_masked: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && reg_wr && hit) |=> (((ctrl_r ^ $past(ctrl_r))
		& ~($past(capability_mask_four) & PRS_WR_MASK)) == 32'h0))
		else $error("Masked bit changed on write");

	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
		(ctrl_r & ~PRS_WR_MASK) == 32'h0)
		else $error("Reserved bit set");

	a_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && reg_wr && hit) |=> ((ctrl_r & PRS_WR_MASK
		& $past(capability_mask_four)) == ($past(reg_wdata) & PRS_WR_MASK
		& $past(capability_mask_four))))
		else $error("Enabled bits not written");

	a_phy_follows: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en |=> (phy_unit_reset == ctrl_r[PRS_PHY_BIT]))
		else $error("Phy reset does not follow bit");

	a_mac_follows: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en |=> (mac_unit_reset == ctrl_r[PRS_MAC_BIT]))
		else $error("Mac reset does not follow bit");

	a_port_follows: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en |=> (port_reset == ctrl_r[PRS_PORT_N-1:0]))
		else $error("Port resets do not follow bits");

	a_read_value: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && reg_rd && hit) |=> (reg_rdata == $past(ctrl_r)))
		else $error("Read data wrong");

	a_hold_reset: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && !reg_wr && phy_unit_reset) |=> phy_unit_reset)
		else $error("Phy released without write");

	// Writes elsewhere, reads and frozen cycles must leave state alone
	a_miss_keeps: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && reg_wr && !hit) |=> $stable(ctrl_r))
		else $error("Write to other address changed register");

	a_no_write_keeps: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && !reg_wr) |=> $stable(ctrl_r))
		else $error("Register changed without a write");

	a_freeze_ctrl: assert property (@(posedge clk_sys) disable iff (rst)
		!clk_en |=> $stable(ctrl_r))
		else $error("Register changed while frozen");

	a_freeze_rdata: assert property (@(posedge clk_sys) disable iff (rst)
		!clk_en |=> $stable(reg_rdata))
		else $error("Read data changed while frozen");

	a_freeze_out: assert property (@(posedge clk_sys) disable iff (rst)
		!clk_en
		|=> $stable({phy_unit_reset, mac_unit_reset, port_reset}))
		else $error("Reset outputs changed while frozen");

	// Read data stands one enabled cycle only, so a stale word cannot be misread
	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && !(reg_rd && hit)) |=> (reg_rdata == 32'h0))
		else $error("Read data not idle");

	a_miss_read: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && reg_rd && !hit) |=> (reg_rdata == 32'h0))
		else $error("Unmapped read not zero");

	a_reserved_read: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && reg_rd && hit) |=> ((reg_rdata & ~PRS_WR_MASK) == 32'h0))
		else $error("Reserved bit read as one");

	a_phy_sets: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && reg_wr && hit && capability_mask_four[PRS_PHY_BIT])
		|=> (phy_unit_reset == $past(reg_wdata[PRS_PHY_BIT])))
		else $error("Phy reset bit not written");

	a_mac_sets: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && reg_wr && hit && capability_mask_four[PRS_MAC_BIT])
		|=> (mac_unit_reset == $past(reg_wdata[PRS_MAC_BIT])))
		else $error("Mac reset bit not written");

	a_mac_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(!(clk_en && reg_wr && hit) && mac_unit_reset) |=> mac_unit_reset)
		else $error("Mac released without write");

	a_phy_low: assert property (@(posedge clk_sys) disable iff (rst)
		(!(clk_en && reg_wr && hit) && !phy_unit_reset) |=> !phy_unit_reset)
		else $error("Phy reset rose without write");

	a_mac_low: assert property (@(posedge clk_sys) disable iff (rst)
		(!(clk_en && reg_wr && hit) && !mac_unit_reset) |=> !mac_unit_reset)
		else $error("Mac reset rose without write");

	// Absent units must never be put into reset by software
	a_phy_absent: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && reg_wr && !capability_mask_four[PRS_PHY_BIT])
		|=> $stable(phy_unit_reset))
		else $error("Absent phy reset changed");

	a_mac_absent: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && reg_wr && !capability_mask_four[PRS_MAC_BIT])
		|=> $stable(mac_unit_reset))
		else $error("Absent mac reset changed");

endmodule : prs_reset_two
`default_nettype wire

//--- bench/tb_top.sv
// Random bench for the second peripheral soft-reset register.
// Assumes prs_pkg and prs_reset_two are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import prs_pkg::*;
;
	logic        clk_sys = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
	logic [11:0] reg_addr = 0, ra;
	logic [31:0] reg_wdata = 0, capability_mask_four = 0, reg_rdata, m = 0;
	logic [31:0] d, k;
	logic        phy_unit_reset, mac_unit_reset;
	logic [6:0]  port_reset;
	int          bad_count = 0, n_tests = 0;
	prs_reset_two dut_u (.clk_sys, .rst, .clk_en, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .capability_mask_four,
		.phy_unit_reset, .mac_unit_reset, .port_reset);
	always #10 clk_sys = ~clk_sys;
	task automatic chk(input logic [31:0] g, e);
		n_tests++;
		if (g !== e) begin
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
			bad_count++;
		end
	endtask : chk
	task automatic report_and_stop;
		if (bad_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		void'($urandom(32'h744f3fcc));
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		#1 chk({phy_unit_reset, mac_unit_reset, port_reset}, '0);
		for (int i = 0; i < 300; i++) begin
			@(posedge clk_sys);
			// Off-target addresses and sparse masks must leave state alone
			ra = $urandom_range(3) ? 12'h048 : 12'($urandom);
			d = $urandom;
			k = $urandom_range(1) ? '1 : $urandom;
			reg_wr <= 1'b1;
			reg_addr <= ra;
			reg_wdata <= d;
			capability_mask_four <= k;
			#1 chk(reg_rdata, '0);
			if (ra == 12'h048) m = (m & ~(k & PRS_WR_MASK)) | (d & k & PRS_WR_MASK);
			@(posedge clk_sys);
			ra = $urandom_range(3) ? 12'h048 : 12'($urandom);
			reg_wr <= 1'b0;
			reg_rd <= 1'b1;
			reg_addr <= ra;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata, ra == 12'h048 ? m : '0);
			chk({phy_unit_reset, mac_unit_reset, port_reset}, {m[30], m[28], m[6:0]});
		end
		// Clock enable low: a write and a read are both ignored
		@(posedge clk_sys);
		clk_en <= 1'b0;
		reg_wr <= 1'b1;
		reg_addr <= PRS_CTRL_TWO_OFS;
		reg_wdata <= m ^ PRS_WR_MASK;
		capability_mask_four <= '1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		clk_en <= 1'b1;
		#1 chk(reg_rdata, '0);
		chk({phy_unit_reset, mac_unit_reset, port_reset}, {m[30], m[28], m[6:0]});
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, m);
		// Reset in mid-run clears every control bit
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		m = '0;
		#1 chk({phy_unit_reset, mac_unit_reset, port_reset}, '0);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_wdata <= PRS_WR_MASK;
		m = PRS_WR_MASK;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, m);
		chk({phy_unit_reset, mac_unit_reset, port_reset}, {m[30], m[28], m[6:0]});
		report_and_stop();
	end
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
